// ===== design/mcd_params.svh
/*
  Constants of the minicomputer register datapath: word width, reset
  values and the one increment step of the program counter.
  Assumes it is included by bare name from the package and modules.
*/
// Contract
// (RULE1) Adder sums source, second operand, carry
// (RULE2) Sum reaches result bus through shifter
// (RULE3) Adder is stateless and purely combinational
// (RULE4) Data register captures memory read word
// (RULE5) Data register holds write word beforehand
// (RULE6) Address register loads, holds whole cycle
// (RULE7) Program counter addresses and auto increments
// (RULE8) Skip or jump loads program counter
// (RULE9) Accumulator is general arithmetic register
// (RULE10) Index register extends accumulator for shifts
// (RULE11) Instruction register holds current instruction
// (RULE12) Operand register holds operand, multiplicand, divisor
// (RULE13) Overflow flag set on arithmetic overflow
// (RULE14) Result bus loads A, X, P, M, W
// (RULE15) Output words pass over result bus
// (RULE16) Source bus selects A, X, P, W, M
// (RULE17) Input data enters on source bus
// (RULE18) Memory data bus carries both directions
// (RULE19) Addresses leave only from address register
// (RULE20) Transfer bus feeds instruction and operand
// (RULE21) Second operand from operand or instruction
// (RULE22) Shifter passes, shifts or rotates sum
// (RULE23) Registers load on clock, one bus driver
`ifndef MCD_PARAMS_SVH
`define MCD_PARAMS_SVH

// ---------------------------------------------------------------
// Widths and reset values
// ---------------------------------------------------------------
`define MCD_WIDTH 16
`define MCD_MIN_WIDTH 2
`define MCD_RST_WORD 16'h0000
`define MCD_RST_BIT 1'b0
`define MCD_PC_STEP 16'h0001

`endif

// ===== design/mcd_pkg.sv
/*
  Types of the minicomputer register datapath: bus selects, shift
  and flag operations, the control word and the register view.
  Assumes the sequencer outside drives one control word per clock.
*/
`include "mcd_params.svh"

package mcd_pkg;

	// ---------------------------------------------------------------
	// Selects and operations
	// ---------------------------------------------------------------
	typedef logic [`MCD_WIDTH-1:0] mcd_word_type;

	typedef enum logic [2:0] {
		MCD_SRC_A = 3'h0,
		MCD_SRC_X = 3'h1,
		MCD_SRC_P = 3'h2,
		MCD_SRC_W = 3'h3,
		MCD_SRC_M = 3'h4,
		MCD_SRC_IO = 3'h5
	} mcd_src_type;

	typedef enum logic [1:0] {
		MCD_U_R = 2'h0,
		MCD_U_I = 2'h1,
		MCD_U_ZERO = 2'h2
	} mcd_usel_type;

	typedef enum logic [2:0] {
		MCD_SH_PASS = 3'h0,
		MCD_SH_LEFT = 3'h1,
		MCD_SH_RIGHT = 3'h2,
		MCD_SH_ROL = 3'h3,
		MCD_SH_ROR = 3'h4
	} mcd_shift_type;

	typedef enum logic [1:0] {
		MCD_FILL_ZERO = 2'h0,
		MCD_FILL_OV = 2'h1,
		MCD_FILL_XHI = 2'h2,
		MCD_FILL_XLO = 2'h3
	} mcd_fill_type;

	typedef enum logic [2:0] {
		MCD_OV_HOLD = 3'h0,
		MCD_OV_ARITH = 3'h1,
		MCD_OV_CLEAR = 3'h2,
		MCD_OV_SET = 3'h3,
		MCD_OV_SHIFT = 3'h4
	} mcd_ov_type;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		mcd_src_type src_sel;
		mcd_usel_type u_sel;
		logic carry_in;
		mcd_shift_type shift_op;
		mcd_fill_type shift_fill;
		logic console_sel;
		logic ld_a;
		logic ld_x;
		logic ld_p;
		logic pc_inc;
		logic ld_w;
		logic ld_i;
		logic ld_r;
		mcd_ov_type ov_op;
		logic mem_start;
		logic mem_write;
		logic io_strobe;
	} mcd_ctrl_type;

	typedef struct packed {
		logic done;
		mcd_word_type rd_data;
	} mcd_mem_in_type;

	typedef struct packed {
		mcd_word_type a;
		mcd_word_type x;
		mcd_word_type p;
		mcd_word_type m;
		mcd_word_type w;
		mcd_word_type i;
		mcd_word_type r;
		logic ov;
	} mcd_regs_type;

endpackage

// ===== design/mcd_adder.sv
/*
  Three-input parallel adder: source word, second operand word and
  carry-in, with carry-out and signed overflow beside the sum.
  Assumes both operand buses are settled within the clock period.
*/
`timescale 1ns/1ps
`include "mcd_params.svh"

module mcd_adder #(
	parameter int WIDTH = `MCD_WIDTH
) (
	input wire logic [WIDTH-1:0] src_word,
	input wire logic [WIDTH-1:0] opd_word,
	input wire logic carry_in,
	output logic [WIDTH-1:0] sum,
	output logic carry_out,
	output logic overflow
);

	// ---------------------------------------------------------------
	// Elaboration check
	// ---------------------------------------------------------------
	if (WIDTH < `MCD_MIN_WIDTH) begin : g_bad_width
		$error("mcd_adder: width too small");
	end

	// ---------------------------------------------------------------
	// Sum
	// ---------------------------------------------------------------
	// No storage and no feedback: output follows inputs at all times
	always_comb begin
		{carry_out, sum} = {1'b0, src_word} + {1'b0, opd_word}
			+ {{WIDTH{1'b0}}, carry_in}; // RULE1 RULE3
		// Same operand signs but a differing result sign
		overflow = (src_word[WIDTH-1] == opd_word[WIDTH-1])
			&& (sum[WIDTH-1] != src_word[WIDTH-1]); // RULE13
	end

endmodule

// ===== design/mcd_shifter.sv
/*
  One-position shift stage between the adder and the result bus:
  pass, shift left or right with a fill bit, rotate left or right.
  Assumes multi-position shifts are made by repeated passes.
*/
`timescale 1ns/1ps
`include "mcd_params.svh"

module mcd_shifter #(
	parameter int WIDTH = `MCD_WIDTH
) (
	input wire logic [WIDTH-1:0] sum,
	input wire mcd_pkg::mcd_shift_type op,
	input wire logic fill,
	output logic [WIDTH-1:0] result,
	output logic out_bit
);

	// ---------------------------------------------------------------
	// Elaboration check
	// ---------------------------------------------------------------
	if (WIDTH < `MCD_MIN_WIDTH) begin : g_bad_width
		$error("mcd_shifter: width too small");
	end

	// ---------------------------------------------------------------
	// Shift gates
	// ---------------------------------------------------------------
	// Only one position per pass keeps the gate depth to one mux
	always_comb begin
		result = sum;
		out_bit = 1'b0;
		case (op)
			mcd_pkg::MCD_SH_LEFT: begin
				result = {sum[WIDTH-2:0], fill}; // RULE22
				out_bit = sum[WIDTH-1];
			end
			mcd_pkg::MCD_SH_RIGHT: begin
				result = {fill, sum[WIDTH-1:1]}; // RULE22
				out_bit = sum[0];
			end
			mcd_pkg::MCD_SH_ROL: begin
				result = {sum[WIDTH-2:0], sum[WIDTH-1]}; // RULE22
				out_bit = sum[WIDTH-1];
			end
			mcd_pkg::MCD_SH_ROR: begin
				result = {sum[0], sum[WIDTH-1:1]}; // RULE22
				out_bit = sum[0];
			end
			default: begin
				result = sum; // RULE22
				out_bit = 1'b0;
			end
		endcase
	end

endmodule

// ===== design/mcd_datapath.sv
/*
  Register datapath of a 16-bit minicomputer processor: source bus,
  second-operand bus, adder, shift stage, result bus, the seven word
  registers, the overflow flag, and the memory and I/O data ports.
  Assumes an outside sequencer drives the control word each clock and
  that memory raises done for one clock to end each memory cycle.
*/
`timescale 1ns/1ps
`include "mcd_params.svh"

module mcd_datapath #(
	parameter int WIDTH = `MCD_WIDTH
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire mcd_pkg::mcd_ctrl_type ctrl,
	input wire mcd_pkg::mcd_word_type console_data,
	input wire mcd_pkg::mcd_mem_in_type mem_in,
	input wire mcd_pkg::mcd_word_type io_in,
	output mcd_pkg::mcd_regs_type regs,
	output mcd_pkg::mcd_word_type mem_addr,
	output logic mem_req,
	output logic mem_we,
	output mcd_pkg::mcd_word_type md_out,
	output logic md_oe,
	output mcd_pkg::mcd_word_type io_out,
	output logic io_oe
);

	// ---------------------------------------------------------------
	// Elaboration check
	// ---------------------------------------------------------------
	// The carriers are fixed at the package width
	if (WIDTH != `MCD_WIDTH) begin : g_bad_width
		$error("mcd_datapath: width must match package word");
	end

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		mcd_pkg::mcd_regs_type regs;
		logic busy;
		logic wr;
		logic md_oe;
		mcd_pkg::mcd_word_type io_data;
		logic io_oe;
	} mcd_state_type;

	mcd_state_type st_q;
	mcd_state_type st_d;
	mcd_pkg::mcd_word_type sbus;
	mcd_pkg::mcd_word_type ubus;
	mcd_pkg::mcd_word_type abus;
	mcd_pkg::mcd_word_type sum;
	mcd_pkg::mcd_word_type shifted;
	logic carry_out;
	logic overflow;
	logic fill;
	logic out_bit;
	logic rd_done;
	logic wr_busy;

	// ---------------------------------------------------------------
	// Buses
	// ---------------------------------------------------------------
	// One select per bus, so each bus has exactly one driver
	always_comb begin
		if (ctrl.src_sel == mcd_pkg::MCD_SRC_A) begin
			sbus = st_q.regs.a; // RULE16 RULE9
		end else if (ctrl.src_sel == mcd_pkg::MCD_SRC_X) begin
			sbus = st_q.regs.x; // RULE16
		end else if (ctrl.src_sel == mcd_pkg::MCD_SRC_P) begin
			sbus = st_q.regs.p; // RULE16
		end else if (ctrl.src_sel == mcd_pkg::MCD_SRC_W) begin
			sbus = st_q.regs.w; // RULE16
		end else if (ctrl.src_sel == mcd_pkg::MCD_SRC_M) begin
			sbus = st_q.regs.m; // RULE16
		end else if (ctrl.src_sel == mcd_pkg::MCD_SRC_IO) begin
			sbus = io_in; // RULE17
		end else begin
			sbus = `MCD_RST_WORD; // RULE23
		end
	end

	// Second operand: operand or instruction register, or nothing
	always_comb begin
		if (ctrl.u_sel == mcd_pkg::MCD_U_R) begin
			ubus = st_q.regs.r; // RULE21 RULE12
		end else if (ctrl.u_sel == mcd_pkg::MCD_U_I) begin
			ubus = st_q.regs.i; // RULE21
		end else begin
			ubus = `MCD_RST_WORD;
		end
	end

	// Fill bit for one-position shifts; the X taps chain long shifts
	always_comb begin
		case (ctrl.shift_fill)
			mcd_pkg::MCD_FILL_OV: fill = st_q.regs.ov;
			mcd_pkg::MCD_FILL_XHI: fill = st_q.regs.x[WIDTH-1]; // RULE10
			mcd_pkg::MCD_FILL_XLO: fill = st_q.regs.x[0]; // RULE10
			default: fill = 1'b0;
		endcase
	end

	mcd_adder #(
		.WIDTH(WIDTH)
	) u_adder (
		.src_word(sbus),
		.opd_word(ubus),
		.carry_in(ctrl.carry_in),
		.sum(sum),
		.carry_out(carry_out),
		.overflow(overflow)
	);

	mcd_shifter #(
		.WIDTH(WIDTH)
	) u_shifter (
		.sum(sum),
		.op(ctrl.shift_op),
		.fill(fill),
		.result(shifted),
		.out_bit(out_bit)
	);

	// Result bus: shift stage or console coupling, never the raw sum
	assign abus = ctrl.console_sel ? console_data : shifted; // RULE2 RULE14

	// A write cycle in flight pins the data register
	assign rd_done = st_q.busy && !st_q.wr && mem_in.done;
	assign wr_busy = st_q.busy && st_q.wr;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.io_oe = 1'b0;
		// Accumulator and index load only from the result bus
		if (ctrl.ld_a) begin
			st_d.regs.a = abus; // RULE9 RULE14
		end
		if (ctrl.ld_x) begin
			st_d.regs.x = abus; // RULE10 RULE14
		end
		// A branch load wins over the automatic step
		if (ctrl.ld_p) begin
			st_d.regs.p = abus; // RULE8 RULE14
		end else if (ctrl.pc_inc) begin
			st_d.regs.p = st_q.regs.p + `MCD_PC_STEP; // RULE7
		end
		// Memory word lands in W when the read completes
		if (rd_done) begin
			st_d.regs.w = mem_in.rd_data; // RULE4 RULE18
		end else if (ctrl.ld_w && !wr_busy) begin
			st_d.regs.w = abus; // RULE5 RULE14
		end
		// Transfer bus from W into instruction and operand registers
		if (ctrl.ld_i) begin
			st_d.regs.i = st_q.regs.w; // RULE20 RULE11
		end
		if (ctrl.ld_r) begin
			st_d.regs.r = st_q.regs.w; // RULE20 RULE12
		end
		// Memory cycle: address taken at start, held until done
		if (st_q.busy) begin
			if (mem_in.done) begin
				st_d.busy = 1'b0;
				st_d.md_oe = 1'b0;
			end
		end else if (ctrl.mem_start) begin
			st_d.busy = 1'b1;
			st_d.wr = ctrl.mem_write;
			st_d.md_oe = ctrl.mem_write; // RULE18
			st_d.regs.m = abus; // RULE6 RULE14 RULE19
		end
		// Overflow flag operations
		case (ctrl.ov_op)
			mcd_pkg::MCD_OV_ARITH: begin
				st_d.regs.ov = st_q.regs.ov | overflow; // RULE13
			end
			mcd_pkg::MCD_OV_CLEAR: st_d.regs.ov = `MCD_RST_BIT; // RULE13
			mcd_pkg::MCD_OV_SET: st_d.regs.ov = 1'b1; // RULE13
			mcd_pkg::MCD_OV_SHIFT: st_d.regs.ov = out_bit; // RULE13
			default: st_d.regs.ov = st_q.regs.ov;
		endcase
		// Outgoing I/O word is whatever sits on the result bus
		if (ctrl.io_strobe) begin
			st_d.io_data = abus; // RULE15
			st_d.io_oe = 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	// Synchronous reset clears every register and cycle flag
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d; // RULE23
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign regs = st_q.regs;
	assign mem_addr = st_q.regs.m; // RULE19
	assign mem_req = st_q.busy;
	assign mem_we = st_q.wr;
	assign md_out = st_q.regs.w; // RULE18
	assign md_oe = st_q.md_oe;
	assign io_out = st_q.io_data;
	assign io_oe = st_q.io_oe;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	chk_adder_sum: assert property ( // RULE1
		sum == sbus + ubus + {{(WIDTH-1){1'b0}}, ctrl.carry_in})
		else $error("adder sum differs from its inputs");

	chk_abus_shift: assert property ( // RULE2
		!ctrl.console_sel && ctrl.shift_op == mcd_pkg::MCD_SH_PASS
		|-> abus == sum)
		else $error("result bus does not carry passed sum");

	chk_mar_hold: assert property ( // RULE6
		st_q.busy && !mem_in.done |=> $stable(mem_addr) && mem_req)
		else $error("address changed during memory cycle");

	chk_mar_load: assert property ( // RULE19
		!st_q.busy && ctrl.mem_start |=> mem_addr == $past(abus))
		else $error("address register missed cycle start");

	chk_w_capture: assert property ( // RULE4
		rd_done |=> regs.w == $past(mem_in.rd_data) && !mem_req)
		else $error("read word not captured");

	chk_w_write_hold: assert property ( // RULE5
		wr_busy |=> $stable(regs.w))
		else $error("write data changed during write cycle");

	chk_pc_step: assert property ( // RULE7
		ctrl.pc_inc && !ctrl.ld_p |=> regs.p == $past(regs.p) + `MCD_PC_STEP)
		else $error("program counter did not step");

	chk_pc_branch: assert property ( // RULE8
		ctrl.ld_p |=> regs.p == $past(abus))
		else $error("branch target not loaded");

	chk_ov_arith: assert property ( // RULE13
		ctrl.ov_op == mcd_pkg::MCD_OV_ARITH && overflow |=> regs.ov)
		else $error("overflow flag not set");

	chk_ir_load: assert property ( // RULE20
		ctrl.ld_i |=> regs.i == $past(regs.w))
		else $error("instruction register missed transfer");

	chk_io_word: assert property ( // RULE15
		ctrl.io_strobe |=> io_oe && io_out == $past(abus) ##1 !io_oe
		or ctrl.io_strobe)
		else $error("output word not taken from result bus");

	chk_md_drive: assert property ( // RULE18
		!st_q.busy && ctrl.mem_start && ctrl.mem_write
		|=> md_oe && mem_we && md_out == $past(regs.w))
		else $error("write data not driven to memory");

	// Register loads that no other check pins down
	chk_r_load: assert property ( // RULE12
		ctrl.ld_r |=> regs.r == $past(regs.w))
		else $error("operand register missed transfer");

	chk_acc_load: assert property ( // RULE9
		ctrl.ld_a |=> regs.a == $past(abus))
		else $error("accumulator missed result bus load");

	chk_index_load: assert property ( // RULE10
		ctrl.ld_x |=> regs.x == $past(abus))
		else $error("index register missed result bus load");

	chk_ov_clear: assert property ( // RULE13
		ctrl.ov_op == mcd_pkg::MCD_OV_CLEAR |=> !regs.ov)
		else $error("overflow flag not cleared");

	// Memory bus is released together with the request
	chk_md_release: assert property ( // RULE18
		st_q.busy && mem_in.done |=> !md_oe && !mem_req)
		else $error("memory data still driven after cycle end");

	cov_read: cover property (rd_done);
	cov_write: cover property (wr_busy && mem_in.done);
	cov_branch: cover property (ctrl.ld_p && ctrl.pc_inc);
	cov_io_out: cover property (ctrl.io_strobe ##1 ctrl.io_strobe);

endmodule

// ===== dv/mcd_mem_model.sv
/*
  Memory partner of the register datapath: stores written words and
  answers each memory cycle with a one-cycle done after lat waits.
  Assumes the datapath holds address and write data until done.
*/
`timescale 1ns/1ps

module mcd_mem_model (
	input wire logic clk_sys,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire mcd_pkg::mcd_word_type mem_addr,
	input wire mcd_pkg::mcd_word_type md_out,
	input wire logic [3:0] lat,
	output mcd_pkg::mcd_mem_in_type mem_in
);
	logic [15:0] mem [logic [15:0]];
	logic [3:0] cnt;

	// Start idle with a known data pattern
	initial begin
		mem_in = {1'b0, 16'h5a3c};
		cnt = 4'h0;
	end

	// Read lines toggle outside an answer so stale data never matches
	always @(posedge clk_sys) begin
		mem_in.rd_data <= ~mem_in.rd_data;
		if (mem_in.done) begin
			mem_in.done <= 1'b0;
			cnt <= 4'h0;
		end else if (mem_req && cnt == lat) begin
			mem_in.done <= 1'b1;
			if (mem_we)
				mem[mem_addr] = md_out;
			else
				mem_in.rd_data <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
		end else if (mem_req) begin
			cnt <= cnt + 4'h1;
		end else begin
			cnt <= 4'h0; // A reset may cut a cycle short
		end
	end
endmodule

// ===== dv/tb_top.sv
/*
  Self-checking bench of the register datapath: a register model in
  the bench follows every control word and is compared each clock.
  Assumes the memory partner model sits on the memory port.
*/
`timescale 1ns/1ps

module tb_top;
	logic clk_sys, rst_n, mem_req, mem_we, md_oe, io_oe, mov, mbusy, mwr;
	logic [3:0] lat;
	mcd_pkg::mcd_ctrl_type ctrl, cst;
	mcd_pkg::mcd_word_type console_data, io_in, mem_addr, md_out, io_out;
	mcd_pkg::mcd_mem_in_type mem_in;
	mcd_pkg::mcd_regs_type regs;
	logic [15:0] ma, mx, mp, mm, mw, mi, mr, mio, ad, dt;
	logic [15:0] bmem [logic [15:0]];
	int failures, cmp_count, cyc;

	mcd_datapath DUT (.clk_sys(clk_sys), .rst_n(rst_n), .ctrl(ctrl),
		.console_data(console_data), .mem_in(mem_in), .io_in(io_in), .regs(regs),
		.mem_addr(mem_addr), .mem_req(mem_req), .mem_we(mem_we), .md_out(md_out),
		.md_oe(md_oe), .io_out(io_out), .io_oe(io_oe));
	mcd_mem_model MEM (.clk_sys(clk_sys), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .md_out(md_out), .lat(lat), .mem_in(mem_in));

	// ---------------------------------------------------------------
	// Clock and hang guard
	// ---------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Run needs about 700 cycles; ceiling leaves ample margin
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			finish_test();
		end
	end

	// ---------------------------------------------------------------
	// Checking helpers
	// ---------------------------------------------------------------
	task automatic finish_test();
		if (failures == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_regs();
		chk("a", ma, regs.a);
		chk("x", mx, regs.x);
		chk("p", mp, regs.p);
		chk("m", mm, regs.m);
		chk("w", mw, regs.w);
		chk("i", mi, regs.i);
		chk("r", mr, regs.r);
		chk("ov", {15'h0000, mov}, {15'h0000, regs.ov});
	endtask

	// One clock: drive at the falling edge, model the edge, compare
	task automatic step(input mcd_pkg::mcd_ctrl_type c, input logic [15:0] cv);
		logic [15:0] s, u, sm, sh, ab;
		logic [16:0] t;
		logic f, ob, ovf, fin, busy0;
		int sv;
		@(negedge clk_sys);
		ctrl = c;
		console_data = cv;
		io_in = 16'($urandom);
		case (c.src_sel)
			mcd_pkg::MCD_SRC_A: s = ma;
			mcd_pkg::MCD_SRC_X: s = mx;
			mcd_pkg::MCD_SRC_P: s = mp;
			mcd_pkg::MCD_SRC_W: s = mw;
			mcd_pkg::MCD_SRC_M: s = mm;
			default: s = io_in;
		endcase
		u = (c.u_sel == mcd_pkg::MCD_U_R) ? mr : (c.u_sel == mcd_pkg::MCD_U_I) ? mi : 16'h0000;
		t = s + u + c.carry_in;
		sm = t[15:0];
		// Signed sum in integers: overflow when it leaves the 16-bit range
		sv = int'($signed(s)) + int'($signed(u)) + int'(c.carry_in);
		ovf = (sv > 32767) || (sv < -32768);
		case (c.shift_fill)
			mcd_pkg::MCD_FILL_OV: f = mov;
			mcd_pkg::MCD_FILL_XHI: f = mx[15];
			mcd_pkg::MCD_FILL_XLO: f = mx[0];
			default: f = 1'b0;
		endcase
		if (c.shift_op == mcd_pkg::MCD_SH_LEFT || c.shift_op == mcd_pkg::MCD_SH_ROL) ob = sm[15];
		else if (c.shift_op == mcd_pkg::MCD_SH_RIGHT || c.shift_op == mcd_pkg::MCD_SH_ROR) ob = sm[0];
		else ob = 1'b0;
		case (c.shift_op)
			mcd_pkg::MCD_SH_LEFT: sh = {sm[14:0], f};
			mcd_pkg::MCD_SH_RIGHT: sh = {f, sm[15:1]};
			mcd_pkg::MCD_SH_ROL: sh = {sm[14:0], sm[15]};
			mcd_pkg::MCD_SH_ROR: sh = {sm[0], sm[15:1]};
			default: sh = sm;
		endcase
		ab = c.console_sel ? cv : sh;
		busy0 = mbusy;
		fin = mbusy && mem_in.done;
		@(posedge clk_sys);
		#1;
		// W copies use the word that stood before the edge
		if (c.ld_i) mi = mw;
		if (c.ld_r) mr = mw;
		if (c.ld_w && !(busy0 && mwr)) mw = ab;
		if (c.ld_a) ma = ab;
		if (c.ld_x) mx = ab;
		if (c.ld_p) mp = ab;
		else if (c.pc_inc) mp = mp + 16'h0001;
		if (c.io_strobe) mio = ab;
		case (c.ov_op)
			mcd_pkg::MCD_OV_ARITH: mov = mov | ovf;
			mcd_pkg::MCD_OV_CLEAR: mov = 1'b0;
			mcd_pkg::MCD_OV_SET: mov = 1'b1;
			mcd_pkg::MCD_OV_SHIFT: mov = ob;
			default: mov = mov;
		endcase
		if (fin) begin
			mbusy = 1'b0;
			if (!mwr) mw = bmem[mm];
		end else if (c.mem_start && !busy0) begin
			mbusy = 1'b1;
			mwr = c.mem_write;
			mm = ab;
		end
		chk_regs();
		chk_regs();
		chk("io_oe", {15'h0000, c.io_strobe}, {15'h0000, io_oe});
		chk("io_out", mio, io_out);
		chk("mem_req", {15'h0000, mbusy}, {15'h0000, mem_req});
		chk("md_oe", {15'h0000, mbusy & mwr}, {15'h0000, md_oe});
		if (mbusy) chk("mem_addr", mm, mem_addr);
		if (mbusy) chk("mem_we", {15'h0000, mwr}, {15'h0000, mem_we});
		if (mbusy && mwr) chk("md_out", mw, md_out);
	endtask

	function automatic mcd_pkg::mcd_ctrl_type rnd_ctrl();
		mcd_pkg::mcd_ctrl_type c;
		logic [15:0] r;
		c = '0;
		r = 16'($urandom);
		c.src_sel = mcd_pkg::mcd_src_type'(3'($urandom_range(5)));
		c.u_sel = mcd_pkg::mcd_usel_type'(2'($urandom_range(2)));
		c.shift_op = mcd_pkg::mcd_shift_type'(3'($urandom_range(4)));
		c.shift_fill = mcd_pkg::mcd_fill_type'(2'($urandom_range(3)));
		c.ov_op = mcd_pkg::mcd_ov_type'(3'($urandom_range(4)));
		{c.carry_in, c.console_sel, c.ld_a, c.ld_x, c.ld_p} = r[5:1];
		{c.pc_inc, c.ld_w, c.ld_i, c.ld_r, c.io_strobe} = r[10:6];
		return c;
	endfunction

	// Memory cycle with a refused second start while busy
	task automatic mem_op(input logic wr, input logic [15:0] a, input logic [15:0] d,
		input logic [3:0] l);
		mcd_pkg::mcd_ctrl_type c;
		c = '0;
		c.console_sel = 1'b1;
		lat = l;
		if (wr) begin
			c.ld_w = 1'b1;
			step(c, d);
			bmem[a] = d;
		end
		c.ld_w = 1'b0;
		c.mem_start = 1'b1;
		c.mem_write = wr;
		step(c, a);
		c.ld_w = wr;
		step(c, ~a);
		c = '0;
		for (int n = 0; n < 20 && mbusy; n++) step(c, d);
		// A cycle that never ends counts as a mismatch
		chk("mem_cycle_end", 16'h0000, {15'h0000, mbusy});
	endtask

	task automatic do_reset();
		@(negedge clk_sys);
		rst_n = 1'b0;
		ctrl = '0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		{ma, mx, mp, mm, mw, mi, mr, mio} = '0;
		{mov, mbusy, mwr} = 3'h0;
		chk_regs();
		chk("rst_out", 16'h0000, {13'h0000, mem_req, md_oe, io_oe});
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		ctrl = '0;
		console_data = 16'h0000;
		io_in = 16'h0000;
		lat = 4'h0;
		failures = 0;
		cmp_count = 0;
		cyc = 0;
		void'($urandom(17));
		do_reset();
		repeat (400) step(rnd_ctrl(), 16'($urandom));
		for (int k = 0; k < 8; k++) begin
			ad = 16'($urandom);
			dt = 16'($urandom);
			mem_op(1'b1, ad, dt, 4'(k % 4));
			mem_op(1'b0, ad, dt, 4'(3 - k % 4));
		end
		// Cycle cut short by a reset in mid-run
		cst = '0;
		cst.mem_start = 1'b1;
		step(cst, 16'h00ff);
		do_reset();
		repeat (200) step(rnd_ctrl(), 16'($urandom));
		finish_test();
	end
endmodule
